// >>> alu_check_sva.sv
`timescale 1ns/10ps
// ****
// Flag and result checks at the ports
// ****
module alu_check (
	input wire clk_sys,
	input wire arst_n,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire [7:0] operand,
	input wire [7:0] cmp_dest,
	input wire [7:0] cmp_src,
	input wire [7:0] acc_reg,
	input wire [7:0] b_reg,
	input wire carry_reg,
	input wire signed_range_flag_reg,
	input wire nibble_carry_flag_reg,
	input wire busy_reg,
	input wire done_reg,
	input wire branch_taken_reg,
	input wire branch_valid_reg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	wire ok = op_valid && !busy_reg;
	wire add = ok && (op_code == 4'h1 || op_code == 4'h2);
	// Carry feeds the sum only for the with-carry form
	wire ci = (op_code == 4'h2) & carry_reg;
	wire [8:0] s = acc_reg + operand + ci;
	wire [7:0] s6 = acc_reg[6:0] + operand[6:0] + ci;
	wire [4:0] s3 = acc_reg[3:0] + operand[3:0] + ci;
	wire [8:0] d = acc_reg - operand - carry_reg;
	wire [15:0] p = acc_reg * b_reg;
	wire bz = b_reg == 8'h00;
	wire ne = cmp_src != cmp_dest;
	wire gt = cmp_src > cmp_dest;
	a_add_carry: assert property (add |=> {carry_reg, acc_reg} == $past(s))
		else $error("sum result or carry wrong");
	a_add_range: assert property (add |=> signed_range_flag_reg == $past(s[8] ^ s6[7]))
		else $error("sum signed range flag wrong");
	a_add_nibble: assert property (add |=> nibble_carry_flag_reg == $past(s3[4]))
		else $error("sum nibble carry wrong");
	a_sub_borrow: assert property (ok && op_code == 4'h3 |=> {carry_reg, acc_reg} == $past(d))
		else $error("difference or borrow wrong");
	a_mul_split: assert property (ok && op_code == 4'h4 |=> {b_reg, acc_reg} == $past(p)
		&& !carry_reg && signed_range_flag_reg == ($past(p) > 16'h00ff))
		else $error("product split or flags wrong");
	a_div_timing: assert property (ok && op_code == 4'h5 |=> busy_reg [*8] ##1 busy_reg
		##1 (done_reg && !carry_reg && signed_range_flag_reg == $past(bz, 10)))
		else $error("quotient timing or flags wrong");
	a_rot_right: assert property (ok && op_code == 4'h7 |=> {acc_reg, carry_reg} ==
		{$past(carry_reg), $past(acc_reg)} && $stable(nibble_carry_flag_reg))
		else $error("rotate right wrong");
	a_rot_left: assert property (ok && op_code == 4'h8 |=> {carry_reg, acc_reg} ==
		{$past(acc_reg), $past(carry_reg)} && $stable(signed_range_flag_reg))
		else $error("rotate left wrong");
	a_cmp_branch: assert property (ok && op_code == 4'h9 |=> branch_valid_reg &&
		branch_taken_reg == $past(ne) && carry_reg == $past(gt))
		else $error("compare branch wrong");
	c_div: cover property (ok && op_code == 4'h5);
	c_adj: cover property (ok && op_code == 4'h6);
	c_taken: cover property (branch_valid_reg && branch_taken_reg);
endmodule // alu_check

// >>> alu_divider.v
`timescale 1ns/10ps
`include "alu_status_defs.vh"
// ********************************
// Restoring divider, one quotient bit per clock
// ********************************
module alu_divider (
	input wire clk_sys,
	input wire arst_n,
	input wire start,
	input wire [7:0] dividend,
	input wire [7:0] divisor,
	output reg busy_reg,
	output reg done_reg,
	output reg [7:0] quot_reg,
	output reg [7:0] rem_reg
);
	reg [3:0] cnt_reg;
	reg [7:0] dvs_reg;
	wire [8:0] trial;
	wire [8:0] diff;
	assign trial = {rem_reg, quot_reg[7]};
	assign diff = trial - {1'b0, dvs_reg};
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			quot_reg <= 8'h00;
			rem_reg <= 8'h00;
			cnt_reg <= 4'h0;
			dvs_reg <= 8'h00;
		end
		else
		begin
			done_reg <= 1'b0;
			if (start && !busy_reg)
			begin
				busy_reg <= 1'b1;
				quot_reg <= dividend;
				rem_reg <= 8'h00;
				dvs_reg <= divisor;
				cnt_reg <= `DIV_CYCLES;
			end
			else if (busy_reg)
			begin
				// Zero divisor just runs through; quotient comes out 0xFF and remainder the dividend
				if (!diff[8])
				begin
					rem_reg <= diff[7:0];
					quot_reg <= {quot_reg[6:0], 1'b1};
				end
				else
				begin
					rem_reg <= trial[7:0];
					quot_reg <= {quot_reg[6:0], 1'b0};
				end
				cnt_reg <= cnt_reg - 4'h1;
				if (cnt_reg == 4'h1)
				begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end
endmodule // alu_divider

// >>> alu_seq_model.sv
`timescale 1ns/10ps
// ****
// Issues one instruction per request, never while busy
// ****
module alu_seq_model (
	input wire clk_sys,
	input wire arst_n,
	input wire req,
	input wire [3:0] req_code,
	input wire busy_reg,
	output reg op_valid,
	output reg [3:0] op_code
);
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			op_valid <= 1'b0;
			op_code <= 4'h0;
		end
		else
		begin
			op_valid <= req && !busy_reg && !op_valid;
			op_code <= req_code;
		end
	end
endmodule // alu_seq_model

// >>> alu_status_defs.vh
`ifndef ALU_STATUS_DEFS_VH
`define ALU_STATUS_DEFS_VH
`define OP_W 4
`define OP_NONE 4'h0
`define OP_SUM 4'h1
`define OP_SUMC 4'h2
`define OP_DIFFERENCE_WITH_BORROW_INSTR 4'h3
`define OP_MUL 4'h4
`define OP_DIV 4'h5
`define OP_DA 4'h6
`define OP_RRC 4'h7
`define OP_RLC 4'h8
`define OP_COMPARE_BRANCH_INSTR 4'h9
`define DIV_CYCLES 4'h8
`define LOW_DIGIT_MAX 8'h09
`define LOW_FIX 8'h06
`define HIGH_FIX 8'h60
`define BCD_MAX 9'h099
`define BYTE_MAX 16'h00ff
`define ACC_RESET 8'h00
`define B_RESET 8'h00
`endif

// >>> mcu_alu_status_flags.v
`timescale 1ns/10ps
`include "alu_status_defs.vh"
module mcu_alu_status_flags (
	input wire clk_sys,
	input wire arst_n,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire [7:0] operand,
	input wire [7:0] cmp_dest,
	input wire [7:0] cmp_src,
	input wire acc_load,
	input wire [7:0] acc_load_data,
	input wire b_load,
	input wire [7:0] b_load_data,
	input wire carry_load,
	input wire carry_load_data,
	output reg [7:0] acc_reg,
	output reg [7:0] b_reg,
	output reg carry_reg,
	output reg signed_range_flag_reg,
	output reg nibble_carry_flag_reg,
	output reg busy_reg,
	output reg done_reg,
	output reg branch_taken_reg,
	output reg branch_valid_reg
);
	// ********************************
	// States
	// ********************************
	localparam ST_IDLE = 2'b01;
	localparam ST_DIV = 2'b10;
	reg [1:0] state_reg;
	reg [1:0] state_next;

	// ********************************
	// Arithmetic helpers
	// ********************************
	// Bitwise carries of a + b + cin; bit i is the carry out of bit i
	function [7:0] add_carries;
		input [7:0] a;
		input [7:0] b;
		input cin;
		integer i;
		reg c;
		begin
			c = cin;
			add_carries = 8'h00;
			for (i = 0; i < 8; i = i + 1)
			begin
				c = (a[i] & b[i]) | (a[i] & c) | (b[i] & c);
				add_carries[i] = c;
			end
		end
	endfunction

	// Bitwise borrows of a - b - bin; bit i is the borrow needed by bit i
	function [7:0] sub_borrows;
		input [7:0] a;
		input [7:0] b;
		input bin;
		integer i;
		reg w;
		begin
			w = bin;
			sub_borrows = 8'h00;
			for (i = 0; i < 8; i = i + 1)
			begin
				w = (~a[i] & b[i]) | (~a[i] & w) | (b[i] & w);
				sub_borrows[i] = w;
			end
		end
	endfunction

	wire is_sumc = (op_code == `OP_SUMC);
	wire add_cin = is_sumc ? carry_reg : 1'b0;
	wire [7:0] add_res = acc_reg + operand + {7'h00, add_cin};
	wire [7:0] add_cy = add_carries(acc_reg, operand, add_cin);
	wire [7:0] sub_res = acc_reg - operand - {7'h00, carry_reg};
	wire [7:0] sub_bw = sub_borrows(acc_reg, operand, carry_reg);
	wire [15:0] product = acc_reg * b_reg;

	// Decimal adjust in two steps, each step a 9-bit sum
	wire low_fix = nibble_carry_flag_reg || ({4'h0, acc_reg[3:0]} > `LOW_DIGIT_MAX);
	wire [8:0] da_step1 = {1'b0, acc_reg} + (low_fix ? {1'b0, `LOW_FIX} : 9'h000);
	wire high_fix = carry_reg || low_fix;
	wire [8:0] da_step2 = da_step1 + (high_fix ? {1'b0, `HIGH_FIX} : 9'h000);
	// Carry reflects the full adjusted value, so a wrap past 0xFF also sets it
	wire da_carry = (da_step2 > `BCD_MAX);

	wire div_busy;
	wire div_done;
	wire [7:0] div_quot;
	wire [7:0] div_rem;
	reg div_zero_reg;
	// Divider busy is checked too, so a stray start can never restart a run
	wire div_start = op_valid && (op_code == `OP_DIV) && (state_reg == ST_IDLE) && !div_busy;
	// Next values of the registers, formed in one combinational process
	reg [7:0] acc_next;
	reg [7:0] b_next;
	reg carry_next;
	reg signed_range_flag_next;
	reg nibble_carry_flag_next;
	reg done_next;
	reg branch_taken_next;
	reg branch_valid_next;
	reg div_zero_next;

	alu_divider u_div (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.start(div_start),
		.dividend(acc_reg),
		.divisor(b_reg),
		.busy_reg(div_busy),
		.done_reg(div_done),
		.quot_reg(div_quot),
		.rem_reg(div_rem)
	);

	// ********************************
	// Sequencer
	// ********************************
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (div_start)
					state_next = ST_DIV;
			ST_DIV:
				if (div_done)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	// ********************************
	// Next values of accumulator, B and flags
	// ********************************
	always @*
	begin
		// Direct loads from the core; an instruction in the same cycle wins
		acc_next = acc_load ? acc_load_data : acc_reg;
		b_next = b_load ? b_load_data : b_reg;
		carry_next = carry_load ? carry_load_data : carry_reg;
		// Unlisted flags are simply not assigned below and hold
		signed_range_flag_next = signed_range_flag_reg;
		nibble_carry_flag_next = nibble_carry_flag_reg;
		done_next = 1'b0;
		branch_taken_next = branch_taken_reg;
		branch_valid_next = 1'b0;
		div_zero_next = div_zero_reg;
		if (state_reg == ST_DIV)
		begin
			// The divider result lands in one step, together with both flags
			if (div_done)
			begin
				acc_next = div_quot;
				b_next = div_rem;
				carry_next = 1'b0;
				signed_range_flag_next = div_zero_reg;
				done_next = 1'b1;
			end
		end
		else if (op_valid)
		begin
			case (op_code)
				`OP_SUM, `OP_SUMC:
				begin
					acc_next = add_res;
					carry_next = add_cy[7];
					signed_range_flag_next = add_cy[6] ^ add_cy[7];
					nibble_carry_flag_next = add_cy[3];
					done_next = 1'b1;
				end
				`OP_DIFFERENCE_WITH_BORROW_INSTR:
				begin
					acc_next = sub_res;
					carry_next = sub_bw[7];
					signed_range_flag_next = sub_bw[6] ^ sub_bw[7];
					nibble_carry_flag_next = sub_bw[3];
					done_next = 1'b1;
				end
				`OP_MUL:
				begin
					acc_next = product[7:0];
					b_next = product[15:8];
					carry_next = 1'b0;
					signed_range_flag_next = (product > `BYTE_MAX);
					done_next = 1'b1;
				end
				`OP_DIV:
					div_zero_next = (b_reg == 8'h00);
				`OP_DA:
				begin
					// Only accumulator and carry change; the nibble carry flag is read, not written
					acc_next = da_step2[7:0];
					carry_next = da_carry;
					done_next = 1'b1;
				end
				`OP_RRC:
				begin
					acc_next = {carry_reg, acc_reg[7:1]};
					carry_next = acc_reg[0];
					done_next = 1'b1;
				end
				`OP_RLC:
				begin
					acc_next = {acc_reg[6:0], carry_reg};
					carry_next = acc_reg[7];
					done_next = 1'b1;
				end
				`OP_COMPARE_BRANCH_INSTR:
				begin
					// Equal values report not taken so the core falls through
					branch_taken_next = (cmp_src != cmp_dest);
					branch_valid_next = 1'b1;
					carry_next = (cmp_src > cmp_dest);
					done_next = 1'b1;
				end
				default:
					done_next = 1'b0;
			endcase
		end
	end

	// ********************************
	// Registers
	// ********************************
	// One process per register keeps each reset value beside its register
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			acc_reg <= `ACC_RESET;
		else
			acc_reg <= acc_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			b_reg <= `B_RESET;
		else
			b_reg <= b_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			carry_reg <= 1'b0;
		else
			carry_reg <= carry_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			signed_range_flag_reg <= 1'b0;
		else
			signed_range_flag_reg <= signed_range_flag_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			nibble_carry_flag_reg <= 1'b0;
		else
			nibble_carry_flag_reg <= nibble_carry_flag_next;
	end

	// Busy follows the next state so it rises with the taking edge
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			busy_reg <= 1'b0;
		else
			busy_reg <= (state_next == ST_DIV);
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			done_reg <= 1'b0;
		else
			done_reg <= done_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			branch_taken_reg <= 1'b0;
		else
			branch_taken_reg <= branch_taken_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			branch_valid_reg <= 1'b0;
		else
			branch_valid_reg <= branch_valid_next;
	end

	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			div_zero_reg <= 1'b0;
		else
			div_zero_reg <= div_zero_next;
	end
endmodule // mcu_alu_status_flags

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
	typedef struct packed {logic [3:0] op; logic [7:0] a, b; logic c;
		logic [7:0] d, ea, eb; logic ec, es, en;} row_t;
	logic clk_sys = 0, arst_n = 0, req = 0, acc_load = 0, b_load = 0;
	logic carry_load = 0, carry_load_data = 0, got = 0;
	logic [3:0] req_code = '0;
	logic [7:0] operand = '0, cmp_dest = '0, cmp_src = '0, acc_load_data = '0, b_load_data = '0;
	wire op_valid, carry_reg, signed_range_flag_reg, nibble_carry_flag_reg, busy_reg;
	wire done_reg, branch_taken_reg, branch_valid_reg;
	wire [3:0] op_code;
	wire [7:0] acc_reg, b_reg;
	int fails = 0, tests_run = 0;
	row_t rows [14] = '{
		'{4'h1,8'h7f,8'h00,1'b1,8'h01,8'h80,8'h00,1'b0,1'b1,1'b1},
		'{4'h1,8'hff,8'h00,1'b0,8'h01,8'h00,8'h00,1'b1,1'b0,1'b1},
		'{4'h2,8'h0e,8'h00,1'b1,8'h01,8'h10,8'h00,1'b0,1'b0,1'b1},
		'{4'h2,8'h80,8'h00,1'b1,8'h80,8'h01,8'h00,1'b1,1'b1,1'b0},
		'{4'h3,8'h00,8'h00,1'b0,8'h01,8'hff,8'h00,1'b1,1'b0,1'b1},
		'{4'h3,8'h80,8'h00,1'b1,8'h00,8'h7f,8'h00,1'b0,1'b1,1'b1},
		'{4'h4,8'h10,8'h10,1'b1,8'h00,8'h00,8'h01,1'b0,1'b1,1'b0},
		'{4'h4,8'h0f,8'h11,1'b1,8'h00,8'hff,8'h00,1'b0,1'b0,1'b0},
		'{4'h5,8'hfb,8'h0a,1'b1,8'h00,8'h19,8'h01,1'b0,1'b0,1'b0},
		'{4'h5,8'h05,8'h00,1'b1,8'h00,8'hff,8'h05,1'b0,1'b1,1'b0},
		'{4'h7,8'h02,8'h00,1'b1,8'h00,8'h81,8'h00,1'b0,1'b0,1'b0},
		'{4'h8,8'h41,8'h00,1'b1,8'h00,8'h83,8'h00,1'b0,1'b0,1'b0},
		'{4'h9,8'h10,8'h00,1'b0,8'h20,8'h10,8'h00,1'b1,1'b1,1'b0},
		'{4'h9,8'h20,8'h00,1'b1,8'h20,8'h20,8'h00,1'b0,1'b0,1'b0}};
	mcu_alu_status_flags DUT (.*);
	alu_seq_model u_seq (.*);
	always #5 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic ld(input logic [7:0] a, input logic [7:0] b, input logic c);
		@(posedge clk_sys);
		#1;
		{acc_load, b_load, carry_load} = 3'b111;
		{acc_load_data, b_load_data, carry_load_data} = {a, b, c};
		@(posedge clk_sys);
		#1;
		{acc_load, b_load, carry_load} = 3'b000;
	endtask
	// Completion is polled with a bound so a lost done cannot hang the run
	task automatic run(input logic [3:0] code, input int n);
		req = 1'b1;
		req_code = code;
		got = 1'b0;
		@(posedge clk_sys);
		#1;
		req = 1'b0;
		repeat (n) if (!got)
		begin
			@(posedge clk_sys);
			#1;
			got = done_reg === 1'b1;
		end
	endtask
	task automatic adj(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ea, input logic ec);
		operand = d;
		ld(a, 8'h00, 1'b0);
		run(4'h1, 4);
		run(4'h6, 4);
		chk(acc_reg, ea);
		chk(carry_reg, ec);
	endtask
	task automatic give_verdict;
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk_sys);
		#1;
		chk({acc_reg, b_reg, carry_reg, signed_range_flag_reg, nibble_carry_flag_reg, done_reg,
			busy_reg, branch_taken_reg, branch_valid_reg}, 32'h0000_0000);
		arst_n = 1'b1;
		foreach (rows[i])
		begin
			{operand, cmp_dest, cmp_src} = {rows[i].d, rows[i].a, rows[i].d};
			ld(rows[i].a, rows[i].b, rows[i].c);
			run(rows[i].op, 12);
			chk(got, 1'b1);
			chk({acc_reg, b_reg}, {rows[i].ea, rows[i].eb});
			chk(carry_reg, rows[i].ec);
			if (rows[i].op < 4'h6)
				chk(signed_range_flag_reg, rows[i].es);
			if (rows[i].op < 4'h4)
				chk(nibble_carry_flag_reg, rows[i].en);
			if (rows[i].op == 4'h9)
				chk({branch_valid_reg, branch_taken_reg}, {1'b1, rows[i].es});
		end
		adj(8'h49, 8'h38, 8'he7, 1'b1);
		adj(8'h90, 8'h90, 8'h80, 1'b0);
		adj(8'h05, 8'h05, 8'h70, 1'b0);
		adj(8'h12, 8'h34, 8'h46, 1'b0);
		// A reset in mid-run stops a quotient in flight and clears all, with no clock edge
		ld(8'h5a, 8'h03, 1'b1);
		run(4'h5, 3);
		chk(busy_reg, 1'b1);
		arst_n = 1'b0;
		#1;
		chk({acc_reg, b_reg, carry_reg, done_reg, busy_reg}, 32'h0000_0000);
		@(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		// An undefined code must leave every register alone and give no done
		ld(8'h55, 8'h00, 1'b1);
		run(4'hf, 4);
		chk({got, carry_reg, acc_reg}, {1'b0, 1'b1, 8'h55});
		give_verdict();
	end
	initial
	begin
		#100000;
		fails++;
		give_verdict();
	end
endmodule // testbench
bind mcu_alu_status_flags alu_check u_chk (.*);
